// ### design/ulsl_line_status.sv
// Line condition register, interrupt requests and transfer halt of the serial port
//
// Summary of operation
// R1: Any error flag set halts the transfer
// R2: Parity error sets flag; write one clears
// R3: Break detect sets flag; write one clears
// R4: Receive-full follows unread data; raises receive request
// R5: Transmit-empty follows holding register; raises transmit request
// R6: Idle only when holding and shift empty
// R7: Overrun, framing set flags; errors raise status
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module ulsl_line_status #(
  parameter int DATA_W = 32
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clkEn, // Clock enable, freezes all state when low
  input wire logic [ulsl_pkg::ADDR_W-1:0] avsAddress, // Avalon byte address
  input wire logic avsRead, // Avalon read
  input wire logic avsWrite, // Avalon write
  input wire logic [DATA_W-1:0] avsWritedata, // Avalon write data
  input wire logic [DATA_W/8-1:0] avsByteenable, // Avalon byte enables
  output logic [DATA_W-1:0] avsReaddata, // Avalon read data
  output logic avsWaitrequest, // Avalon wait request
  input wire logic overrunEvt, // Receiver overrun pulse
  input wire logic parityEvt, // Parity failure pulse
  input wire logic framingEvt, // Bad stop bit pulse
  input wire logic breakEvt, // Break detected pulse
  input wire logic rxDataValid, // Receive data register holds unread data
  input wire logic txDataEmpty, // Transmit data register empty
  input wire logic txShiftEmpty, // Transmit shift register empty
  output logic transferHalt, // Stop the receive data mover
  output logic rxIrqReq, // Receive interrupt request
  output logic txIrqReq, // Transmit interrupt request
  output logic statusIrqReq, // Status interrupt request
  output logic irq // Masked sticky event interrupt
);
  typedef struct packed {
    logic [7:0] lineCond_r;
    logic [3:0] irqStat_r;
    logic [3:0] irqMask_r;
    logic [2:0] reqEn_r;
    logic [DATA_W-1:0] rdData_r;
    logic ack_r;
    logic waitReq_r;
    logic halt_r;
    logic rxReq_r;
    logic txReq_r;
    logic stReq_r;
    logic irq_r;
  } ulsl_state_t;

  ulsl_state_t st_r;
  ulsl_state_t st_nxt;
  logic [3:0] errFlags;
  logic [3:0] errEvt;
  logic [3:0] errClr;
  logic busWr;
  logic wrLow;

  initial begin
    if (DATA_W != 32) begin
      $error("DATA_W must be 32");
    end
  end

  function automatic logic hitIdx(input logic [ulsl_pkg::ADDR_W-1:0] a,
                                  input logic [15:0] idx);
    hitIdx = (a[1:0] == 2'h0) && (a[ulsl_pkg::ADDR_W-1:2] == idx);
  endfunction : hitIdx

  assign errEvt = {breakEvt, framingEvt, parityEvt, overrunEvt}; // [R2] [R3] [R7]
  // A write is taken in the single cycle its answer is given
  assign busWr = avsWrite && st_r.ack_r;
  assign wrLow = busWr && avsByteenable[0];
  assign errClr = (wrLow && hitIdx(avsAddress, ulsl_pkg::LINE_COND_IDX))
                  ? avsWritedata[3:0] : 4'h0; // [R2] [R3] [R7]

  ulsl_err_flags #(.WIDTH(4)) u_err (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .setEvt(errEvt),
    .clrMask(errClr),
    .flags(errFlags)
  );

  always_comb begin
    logic [7:0] lc;
    logic [3:0] evts;
    lc = 8'h00;
    evts = 4'h0;
    st_nxt = st_r;
    // Status bits shown next cycle; error bits track the sticky flags
    lc[3:0] = errFlags;
    lc[ulsl_pkg::RX_FULL_BIT] = rxDataValid; // [R4]
    lc[ulsl_pkg::TX_EMPTY_BIT] = txDataEmpty; // [R5]
    lc[ulsl_pkg::IDLE_BIT] = txDataEmpty && txShiftEmpty; // [R6]
    st_nxt.lineCond_r = lc;
    st_nxt.halt_r = |(errFlags & ulsl_pkg::ERR_MASK); // [R1]
    st_nxt.rxReq_r = rxDataValid && st_r.reqEn_r[ulsl_pkg::EN_RX_BIT]; // [R4]
    st_nxt.txReq_r = txDataEmpty && st_r.reqEn_r[ulsl_pkg::EN_TX_BIT]; // [R5]
    st_nxt.stReq_r = (|errFlags) && st_r.reqEn_r[ulsl_pkg::EN_ST_BIT]; // [R7]
    // Sticky event bits: error rises, set wins over clear
    evts = errEvt;
    st_nxt.irqStat_r = st_r.irqStat_r;
    if (wrLow && hitIdx(avsAddress, ulsl_pkg::IRQ_STAT_IDX)) begin
      st_nxt.irqStat_r = st_r.irqStat_r & ~avsWritedata[3:0];
    end
    st_nxt.irqStat_r = st_nxt.irqStat_r | evts;
    if (wrLow && hitIdx(avsAddress, ulsl_pkg::IRQ_MASK_IDX)) begin
      st_nxt.irqMask_r = avsWritedata[3:0];
    end
    if (wrLow && hitIdx(avsAddress, ulsl_pkg::REQ_ENABLE_IDX)) begin
      st_nxt.reqEn_r = avsWritedata[2:0];
    end
    st_nxt.irq_r = |(st_nxt.irqStat_r & st_nxt.irqMask_r);
    // One wait cycle, then the answer
    st_nxt.ack_r = (avsRead || avsWrite) && !st_r.ack_r;
    // Registered so the bus sees wait request straight from a flop
    st_nxt.waitReq_r = !st_nxt.ack_r;
    st_nxt.rdData_r = st_r.rdData_r;
    if (avsRead && !st_r.ack_r) begin
      if (hitIdx(avsAddress, ulsl_pkg::LINE_COND_IDX)) begin
        st_nxt.rdData_r = {24'h0, st_r.lineCond_r};
      end else if (hitIdx(avsAddress, ulsl_pkg::IRQ_STAT_IDX)) begin
        st_nxt.rdData_r = {28'h0, st_r.irqStat_r};
      end else if (hitIdx(avsAddress, ulsl_pkg::IRQ_MASK_IDX)) begin
        st_nxt.rdData_r = {28'h0, st_r.irqMask_r};
      end else if (hitIdx(avsAddress, ulsl_pkg::REQ_ENABLE_IDX)) begin
        st_nxt.rdData_r = {29'h0, st_r.reqEn_r};
      end else begin
        st_nxt.rdData_r = ulsl_pkg::UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.lineCond_r <= ulsl_pkg::LINE_COND_RESET; // [R5] [R6]
      st_r.waitReq_r <= 1'b1;
      st_r.irqMask_r <= ulsl_pkg::IRQ_MASK_RESET;
      st_r.reqEn_r <= ulsl_pkg::REQ_ENABLE_RESET;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign avsReaddata = st_r.rdData_r;
  assign avsWaitrequest = st_r.waitReq_r;
  assign transferHalt = st_r.halt_r;
  assign rxIrqReq = st_r.rxReq_r;
  assign txIrqReq = st_r.txReq_r;
  assign statusIrqReq = st_r.stReq_r;
  assign irq = st_r.irq_r;

  chk_halt_follows_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> (transferHalt == |$past(errFlags))) // [R1]
    else $error("Halt does not follow error flags");
  chk_par_clear_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && errClr[1] && !parityEvt |=> !errFlags[1]) // [R2]
    else $error("Parity flag not cleared by one");
  chk_brk_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && breakEvt ##1 clkEn |=> st_r.lineCond_r[ulsl_pkg::BREAK_BIT]) // [R3]
    else $error("Break not shown in line condition");
  chk_rx_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> (rxIrqReq == ($past(rxDataValid) && $past(st_r.reqEn_r[0])))) // [R4]
    else $error("Receive request wrong");
  chk_tx_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> (txIrqReq == ($past(txDataEmpty) && $past(st_r.reqEn_r[1])))) // [R5]
    else $error("Transmit request wrong");
  chk_idle_both_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && !(txDataEmpty && txShiftEmpty) |=> !st_r.lineCond_r[6]) // [R6]
    else $error("Idle set while transmitter busy");
  chk_status_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && overrunEvt ##1 clkEn && st_r.reqEn_r[2] |=> statusIrqReq) // [R7]
    else $error("Overrun did not raise status request");
  chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("Bus answer not given in one cycle");
  cov_halt: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(transferHalt));
  cov_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
  cov_clr: cover property (@(posedge sys_clk) disable iff (!rst_n) |errClr);
endmodule : ulsl_line_status

// ### design/ulsl_pkg.sv
// Package of constants for the serial line-status logic
package ulsl_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] LINE_COND_IDX = 16'hFFA5;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hFFB0;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hFFB1;
  localparam logic [15:0] REQ_ENABLE_IDX = 16'hFFB2;
  localparam int ADDR_W = 18;
  // Line condition bit positions
  localparam int OVERRUN_BIT = 0;
  localparam int PARITY_BIT = 1;
  localparam int FRAMING_BIT = 2;
  localparam int BREAK_BIT = 3;
  localparam int RX_FULL_BIT = 4;
  localparam int TX_EMPTY_BIT = 5;
  localparam int IDLE_BIT = 6;
  localparam logic [3:0] ERR_MASK = 4'hF;
  localparam logic [7:0] LINE_COND_RESET = 8'h60;
  // Request enable bits
  localparam int EN_RX_BIT = 0;
  localparam int EN_TX_BIT = 1;
  localparam int EN_ST_BIT = 2;
  localparam logic [2:0] REQ_ENABLE_RESET = 3'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : ulsl_pkg

// ### design/ulsl_err_flags.sv
// Sticky write-one-to-clear error flags of the line condition register
`timescale 1ns/1ps
module ulsl_err_flags #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clkEn, // Clock enable
  input wire logic [WIDTH-1:0] setEvt, // Error events from the receiver
  input wire logic [WIDTH-1:0] clrMask, // Write-one-to-clear bits
  output logic [WIDTH-1:0] flags // Sticky flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags_r;
  } ulsl_flag_st_t;
  ulsl_flag_st_t st_r;
  ulsl_flag_st_t st_nxt;

  initial begin
    if (WIDTH < 1) begin
      $error("WIDTH must be at least one");
    end
  end

  // Set wins over a simultaneous clear so no event is lost
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags_r = (st_r.flags_r & ~clrMask) | setEvt; // [R2] [R3] [R7]
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags_r;

  chk_flag_set_sticks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && (setEvt != '0) |=> ((flags & $past(setEvt)) == $past(setEvt))) // [R2]
    else $error("Error event did not set its flag");
  chk_zero_write_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && (clrMask == '0) |=> ((flags & $past(flags)) == $past(flags))) // [R3]
    else $error("Flag lost without a clear");
endmodule : ulsl_err_flags

// ### tb/ulsl_rx_model.sv
// Receiver event source at the far side of the line status logic
`timescale 1ns/1ps
module ulsl_rx_model (
  input wire logic sys_clk, // System clock
  input wire logic [3:0] errReq, // Errors to report
  output logic [3:0] errEvt // One-cycle event pulses
);
  // One pulse per request, as a receiver flags one character at a time
  always_ff @(posedge sys_clk) begin
    errEvt <= errReq;
  end
endmodule : ulsl_rx_model

// ### tb/tb.sv
// Self-checking bench of the serial line-status logic
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] LC = ulsl_pkg::LINE_COND_IDX;
  logic sys_clk, rst_n, clkEn, avsRead, avsWrite, rxV, txEmpty, txS;
  logic [17:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic avsWaitrequest, halt, rxReq, txReq, stReq, irq;
  logic [3:0] errReq, errEvt;
  int n_mismatch = 0;
  int checked = 0;
  ulsl_rx_model farEnd (.sys_clk(sys_clk), .errReq(errReq), .errEvt(errEvt));
  ulsl_line_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(4'hF), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .overrunEvt(errEvt[0]), .parityEvt(errEvt[1]),
    .framingEvt(errEvt[2]), .breakEvt(errEvt[3]), .rxDataValid(rxV),
    .txDataEmpty(txEmpty), .txShiftEmpty(txS), .transferHalt(halt),
    .rxIrqReq(rxReq), .txIrqReq(txReq), .statusIrqReq(stReq), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  // Request held until waitrequest is sampled low, then released
  task bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= wd;
    avsWrite <= wr;
    avsRead <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : bus
  task reset_values;
    bus(1'b0, LC, 32'h0);
    chk("line cond", 32'h0000_0060, rd);
    chk("halt", 32'h0, {31'h0, halt});
    chk("tx req", 32'h0, {31'h0, txReq});
    bus(1'b0, 16'h0010, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : reset_values
  task error_flags;
    logic [7:0] bv;
    bus(1'b1, ulsl_pkg::REQ_ENABLE_IDX, 32'h0000_0007);
    for (int b = 0; b < 4; b++) begin
      bv = 8'h01 << b;
      // Mask off parity once so the sticky interrupt is seen gated
      bus(1'b1, ulsl_pkg::IRQ_MASK_IDX, (b == 1) ? 32'h0 : 32'h0000_000F);
      errReq <= bv[3:0];
      tick(1);
      errReq <= 4'h0;
      tick(3);
      bus(1'b0, LC, 32'h0);
      chk("flag set", {24'h0, 8'h60 | bv}, rd);
      chk("halt", 32'h1, {31'h0, halt});
      chk("status req", 32'h1, {31'h0, stReq});
      chk("irq", {31'h0, b != 1}, {31'h0, irq});
      bus(1'b1, LC, 32'h0);
      bus(1'b0, LC, 32'h0);
      chk("flag kept", {24'h0, 8'h60 | bv}, rd);
      bus(1'b1, LC, {24'h0, bv});
      bus(1'b0, LC, 32'h0);
      chk("flag clear", 32'h0000_0060, rd);
      tick(2);
      chk("halt", 32'h0, {31'h0, halt});
      chk("status req", 32'h0, {31'h0, stReq});
      bus(1'b1, ulsl_pkg::IRQ_STAT_IDX, 32'h0000_000F);
      tick(2);
      chk("irq", 32'h0, {31'h0, irq});
    end
  endtask : error_flags
  // An event that arrives while the enable is low is not recorded
  task freeze_hold;
    clkEn <= 1'b0;
    errReq <= 4'h4;
    tick(1);
    errReq <= 4'h0;
    tick(3);
    clkEn <= 1'b1;
    tick(2);
    chk("frozen halt", 32'h0, {31'h0, halt});
    bus(1'b0, LC, 32'h0);
    chk("frozen flags", 32'h0000_0060, rd);
  endtask : freeze_hold
  task line_levels;
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      rxV <= v[2];
      txEmpty <= v[1];
      txS <= v[0];
      tick(3);
      bus(1'b0, LC, 32'h0);
      chk("levels", {25'h0, v[1] & v[0], v[1], v[2], 4'h0}, rd);
      chk("rx req", {31'h0, v[2]}, {31'h0, rxReq});
      chk("tx req", {31'h0, v[1]}, {31'h0, txReq});
    end
  endtask : line_levels
  initial begin
    rst_n = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = '0;
    avsWritedata = '0;
    errReq = 4'h0;
    clkEn = 1'b1;
    rxV = 1'b0;
    txEmpty = 1'b1;
    txS = 1'b1;
    tick(10);
    rst_n <= 1'b1;
    reset_values();
    error_flags();
    freeze_hold();
    line_levels();
    give_verdict();
  end
endmodule : tb
